/* File: design/wffr_byte_cmp.v */
// Masked byte comparator with an enable; a disabled byte always agrees.
`timescale 1ns/1ps
`default_nettype none

module wffr_byte_cmp #(
	parameter W = 8
) (
	// Received and expected bits.
	input wire [W-1:0] rx,
	input wire [W-1:0] expected,
	// A one compares the bit, a zero ignores it.
	input wire [W-1:0] mask,
	// Low when this byte lies outside the payload.
	input wire enable,
	// High when every compared bit agrees.
	output wire hit
);

	// Only masked-in bits can cause a mismatch.
	assign hit = !enable || (((rx ^ expected) & mask) == {W{1'b0}});

endmodule
`default_nettype wire

/* File: design/wffr_byte_reg.v */
// One byte-wide configuration register with reserved bits and restart retention.
`timescale 1ns/1ps
`default_nettype none
`include "wffr_defines.vh"

module wffr_byte_reg #(
	parameter [7:0] WRITE_MASK = `WFFR_RW_FULL,
	parameter [7:0] KEEP_MASK = `WFFR_KEEP_FULL
) (
	// Clock and resets.
	input wire clk,
	input wire arst_n,
	input wire soft_rst,
	input wire restart,
	// Write port.
	input wire we,
	input wire [7:0] wdata,
	// Stored value and change flag.
	output reg [7:0] q,
	output wire changed
);

	// A write counts as a change only when the stored bits would differ.
	assign changed = we && ((wdata & WRITE_MASK) != q);

	// Soft reset beats restart, and restart beats a write in the same cycle.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= `WFFR_RESET_BYTE;
		end else if (soft_rst) begin
			q <= `WFFR_RESET_BYTE;
		end else if (restart) begin
			// Kept bits stay, forced bits drop to zero.
			q <= q & KEEP_MASK;
		end else if (we) begin
			// Reserved positions never store a one, so they read back zero.
			q <= wdata & WRITE_MASK;
		end
	end

endmodule
`default_nettype wire

/* File: design/wffr_defines.vh */
// Constants shared by the wake frame filter register bank.
`ifndef WFFR_DEFINES_VH
`define WFFR_DEFINES_VH

// Seven-bit register addresses, one byte per address.
`define WFFR_ADDR_W 7
`define WFFR_ADDR_MASK_MID_HIGH 7'h28
`define WFFR_ADDR_MASK_MID_LOW 7'h29
`define WFFR_ADDR_MASK_LOWEST 7'h2A
`define WFFR_ADDR_LENGTH_CODE 7'h2B
`define WFFR_ADDR_BYTE_SEVEN 7'h2C
`define WFFR_ADDR_BYTE_SIX 7'h2D
`define WFFR_ADDR_BYTE_FIVE 7'h2E
`define WFFR_ADDR_BYTE_FOUR 7'h2F
`define WFFR_ADDR_BYTE_THREE 7'h30

// Power-on and soft reset value of every register.
`define WFFR_RESET_BYTE 8'h00
// Read data for an unmapped address.
`define WFFR_UNMAPPED_BYTE 8'h00

// Writable bit masks; cleared bits are reserved and read as zero.
`define WFFR_RW_FULL 8'hFF
`define WFFR_RW_MASK_LOWEST 8'h7C
`define WFFR_RW_LENGTH_CODE 8'h0F

// Bits kept across a restart; cleared bits are forced to zero.
`define WFFR_KEEP_FULL 8'hFF
`define WFFR_KEEP_LENGTH_CODE 8'h0F

// Length code field layout and decoding.
`define WFFR_DLC_MSB 3
`define WFFR_DLC_LONG_BIT 3
`define WFFR_DLC_LEN_MAX 4'h8
`define WFFR_DLC_ZERO 1'b0

// Mask bits for identifier bits 4 to 0 sit in register bits 6 to 2.
`define WFFR_ID_LOW_POS 2
`define WFFR_ID_LOW_MSB 6

// Index of the first expected byte held in this bank.
`define WFFR_FIRST_DATA_IDX 3
`define WFFR_DATA_BYTES 5

`endif

/* File: design/wffr_top.v */
// Wake frame filter register bank: mask, length code and expected bytes 7 to 3.
`timescale 1ns/1ps
`default_nettype none
`include "wffr_defines.vh"

module wffr_top #(
	parameter ADDR_W = `WFFR_ADDR_W
) (
	// Clock and power-on reset.
	input wire CLK,
	input wire ARST_N,
	// Device-level reset and restart events, one-cycle pulses.
	input wire SOFT_RST,
	input wire RESTART,
	// Register access from the serial interface front end.
	input wire [ADDR_W-1:0] ADDR,
	input wire WR,
	input wire [7:0] WDATA,
	input wire RD,
	output reg [7:0] RDATA,
	output reg RD_VALID,
	output reg ADDR_OK,
	// Configuration-valid control and clearing events.
	input wire CFG_SET,
	input wire WAKE,
	input wire STOP_MODE,
	input wire EXT_CFG_WR,
	input wire EXT_CFG_CHANGED,
	output reg FILTER_CONFIG_VALID,
	// Expected identifier bits 20..0 held by the neighbouring bank.
	input wire [20:0] EXP_ID,
	// Received frame fields, sampled on RX_VALID.
	input wire RX_VALID,
	input wire [20:0] RX_ID,
	input wire [3:0] RX_DLC,
	input wire [7:0] RX_BYTE_SEVEN,
	input wire [7:0] RX_BYTE_SIX,
	input wire [7:0] RX_BYTE_FIVE,
	input wire [7:0] RX_BYTE_FOUR,
	input wire [7:0] RX_BYTE_THREE,
	// Partial compare results, registered.
	output reg MATCH_VALID,
	output reg ID_LOW_MATCH,
	output reg DLC_MATCH,
	output reg DATA_MATCH,
	output reg [3:0] PAYLOAD_LEN
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	// Write strobes, one per register in table order.
	wire we_mask_mid_high = WR && (ADDR == `WFFR_ADDR_MASK_MID_HIGH);
	wire we_mask_mid_low = WR && (ADDR == `WFFR_ADDR_MASK_MID_LOW);
	wire we_mask_lowest = WR && (ADDR == `WFFR_ADDR_MASK_LOWEST);
	wire we_length_code = WR && (ADDR == `WFFR_ADDR_LENGTH_CODE);
	wire we_byte_seven = WR && (ADDR == `WFFR_ADDR_BYTE_SEVEN);
	wire we_byte_six = WR && (ADDR == `WFFR_ADDR_BYTE_SIX);
	wire we_byte_five = WR && (ADDR == `WFFR_ADDR_BYTE_FIVE);
	wire we_byte_four = WR && (ADDR == `WFFR_ADDR_BYTE_FOUR);
	wire we_byte_three = WR && (ADDR == `WFFR_ADDR_BYTE_THREE);

	// Stored register values.
	wire [7:0] id_mask_mid_high;
	wire [7:0] id_mask_mid_low;
	wire [7:0] id_mask_lowest;
	wire [7:0] expected_length_code;
	wire [7:0] expected_byte_seven;
	wire [7:0] expected_byte_six;
	wire [7:0] expected_byte_five;
	wire [7:0] expected_byte_four;
	wire [7:0] expected_byte_three;

	// Per-register change flags.
	wire [8:0] chg;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	// Mask for identifier bits 20..13, fully writable.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_FULL), .KEEP_MASK(`WFFR_KEEP_FULL)) u_mask_mid_high (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_mask_mid_high), .wdata(WDATA), .q(id_mask_mid_high), .changed(chg[0])
	);

	// Mask for identifier bits 12..5, fully writable.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_FULL), .KEEP_MASK(`WFFR_KEEP_FULL)) u_mask_mid_low (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_mask_mid_low), .wdata(WDATA), .q(id_mask_mid_low), .changed(chg[1])
	);

	// Mask for identifier bits 4..0; bits 7 and 1..0 are reserved.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_MASK_LOWEST), .KEEP_MASK(`WFFR_KEEP_FULL)) u_mask_lowest (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_mask_lowest), .wdata(WDATA), .q(id_mask_lowest), .changed(chg[2])
	);

	// Length code; the upper nibble is reserved and dropped on restart.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_LENGTH_CODE), .KEEP_MASK(`WFFR_KEEP_LENGTH_CODE)) u_length (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_length_code), .wdata(WDATA), .q(expected_length_code), .changed(chg[3])
	);

	// Expected payload bytes, bit 0 least significant.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_FULL), .KEEP_MASK(`WFFR_KEEP_FULL)) u_byte_seven (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_byte_seven), .wdata(WDATA), .q(expected_byte_seven), .changed(chg[4])
	);

	// Expected byte six.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_FULL), .KEEP_MASK(`WFFR_KEEP_FULL)) u_byte_six (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_byte_six), .wdata(WDATA), .q(expected_byte_six), .changed(chg[5])
	);

	// Expected byte five.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_FULL), .KEEP_MASK(`WFFR_KEEP_FULL)) u_byte_five (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_byte_five), .wdata(WDATA), .q(expected_byte_five), .changed(chg[6])
	);

	// Expected byte four.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_FULL), .KEEP_MASK(`WFFR_KEEP_FULL)) u_byte_four (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_byte_four), .wdata(WDATA), .q(expected_byte_four), .changed(chg[7])
	);

	// Expected byte three.
	wffr_byte_reg #(.WRITE_MASK(`WFFR_RW_FULL), .KEEP_MASK(`WFFR_KEEP_FULL)) u_byte_three (
		.clk(CLK), .arst_n(ARST_N), .soft_rst(SOFT_RST), .restart(RESTART),
		.we(we_byte_three), .wdata(WDATA), .q(expected_byte_three), .changed(chg[8])
	);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration-valid flag.

	// Any write that hits this bank, changed or not.
	wire any_bank_wr = we_mask_mid_high || we_mask_mid_low || we_mask_lowest ||
		we_length_code || we_byte_seven || we_byte_six || we_byte_five ||
		we_byte_four || we_byte_three;

	// A write that really alters stored filter data.
	wire cfg_changed = (|chg) || EXT_CFG_CHANGED;

	// In stop mode even a same-value write invalidates the configuration.
	wire stop_wr = STOP_MODE && (any_bank_wr || EXT_CFG_WR);

	// All reasons to drop the flag.
	wire cfg_clear = WAKE || SOFT_RST || cfg_changed || stop_wr;

	// Clearing wins over a host set in the same cycle, because a set that
	// races a configuration change would vouch for data the host never checked.
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			FILTER_CONFIG_VALID <= 1'b0;
		end else if (cfg_clear) begin
			FILTER_CONFIG_VALID <= 1'b0;
		end else if (CFG_SET) begin
			FILTER_CONFIG_VALID <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	// Combinational read selection; unmapped addresses read zero.
	reg [7:0] next_rdata;
	reg next_addr_ok;
	always @* begin
		next_rdata = `WFFR_UNMAPPED_BYTE;
		next_addr_ok = 1'b1;
		case (ADDR)
			`WFFR_ADDR_MASK_MID_HIGH: next_rdata = id_mask_mid_high;
			`WFFR_ADDR_MASK_MID_LOW: next_rdata = id_mask_mid_low;
			`WFFR_ADDR_MASK_LOWEST: next_rdata = id_mask_lowest;
			`WFFR_ADDR_LENGTH_CODE: next_rdata = expected_length_code;
			`WFFR_ADDR_BYTE_SEVEN: next_rdata = expected_byte_seven;
			`WFFR_ADDR_BYTE_SIX: next_rdata = expected_byte_six;
			`WFFR_ADDR_BYTE_FIVE: next_rdata = expected_byte_five;
			`WFFR_ADDR_BYTE_FOUR: next_rdata = expected_byte_four;
			`WFFR_ADDR_BYTE_THREE: next_rdata = expected_byte_three;
			default: begin
				// Outside this bank: zero data and no acknowledge of the address.
				next_rdata = `WFFR_UNMAPPED_BYTE;
				next_addr_ok = 1'b0;
			end
		endcase
	end

	// Read data is captured on RD and held until the next read.
	// A read in the same cycle as a write returns the old value.
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= `WFFR_UNMAPPED_BYTE;
			RD_VALID <= 1'b0;
			ADDR_OK <= 1'b0;
		end else begin
			RD_VALID <= RD;
			if (RD) begin
				RDATA <= next_rdata;
				ADDR_OK <= next_addr_ok;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Length code decoding and payload window.

	// Codes above seven all stand for the eight-byte maximum.
	wire [3:0] cfg_dlc = expected_length_code[`WFFR_DLC_MSB:0];
	wire [3:0] payload_len = cfg_dlc[`WFFR_DLC_LONG_BIT] ? `WFFR_DLC_LEN_MAX :
		{`WFFR_DLC_ZERO, cfg_dlc[2:0]};

	// Equivalent lengths with other codes are refused; all four bits must agree.
	wire dlc_hit = (RX_DLC == cfg_dlc);

	////////////////////////////////////////////////////////////////////////////////
	// Identifier compare for bits 20..0.

	wire id_hit_high;
	wire id_hit_mid;
	wire id_hit_low;

	// Identifier bits 20..13 under the mid-high mask.
	wffr_byte_cmp #(.W(8)) u_id_cmp_high (
		.rx(RX_ID[20:13]), .expected(EXP_ID[20:13]), .mask(id_mask_mid_high),
		.enable(1'b1), .hit(id_hit_high)
	);

	// Identifier bits 12..5 under the mid-low mask.
	wffr_byte_cmp #(.W(8)) u_id_cmp_mid (
		.rx(RX_ID[12:5]), .expected(EXP_ID[12:5]), .mask(id_mask_mid_low),
		.enable(1'b1), .hit(id_hit_mid)
	);

	// Identifier bits 4..0 under mask bits 6..2 of the lowest register.
	wffr_byte_cmp #(.W(5)) u_id_cmp_low (
		.rx(RX_ID[4:0]), .expected(EXP_ID[4:0]),
		.mask(id_mask_lowest[`WFFR_ID_LOW_MSB:`WFFR_ID_LOW_POS]),
		.enable(1'b1), .hit(id_hit_low)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Payload compare for bytes 7..3.

	// Byte k of these vectors is payload byte three plus k.
	wire [39:0] rx_bytes = {RX_BYTE_SEVEN, RX_BYTE_SIX, RX_BYTE_FIVE, RX_BYTE_FOUR,
		RX_BYTE_THREE};
	wire [39:0] exp_bytes = {expected_byte_seven, expected_byte_six, expected_byte_five,
		expected_byte_four, expected_byte_three};
	wire [`WFFR_DATA_BYTES-1:0] byte_hit;

	// Bytes at or beyond the decoded length are outside the payload and skipped.
	genvar k;
	generate
		for (k = 0; k < `WFFR_DATA_BYTES; k = k + 1) begin : g_data
			// Index is worked out at full width, then cut to the length width.
			localparam integer BYTE_IDX_FULL = `WFFR_FIRST_DATA_IDX + k;
			localparam [3:0] BYTE_IDX = BYTE_IDX_FULL[3:0];
			wffr_byte_cmp #(.W(8)) u_data_cmp (
				.rx(rx_bytes[8*k+7:8*k]), .expected(exp_bytes[8*k+7:8*k]),
				.mask(`WFFR_RW_FULL), .enable(BYTE_IDX < payload_len),
				.hit(byte_hit[k])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Registered compare results.

	// The three match flags are captured per received frame and held until the next one,
	// so downstream wake logic sees stable levels between frames.
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			MATCH_VALID <= 1'b0;
			ID_LOW_MATCH <= 1'b0;
			DLC_MATCH <= 1'b0;
			DATA_MATCH <= 1'b0;
			PAYLOAD_LEN <= `WFFR_DLC_LEN_MAX & 4'h0;
		end else begin
			MATCH_VALID <= RX_VALID;
			PAYLOAD_LEN <= payload_len;
			if (RX_VALID) begin
				ID_LOW_MATCH <= id_hit_high && id_hit_mid && id_hit_low;
				DLC_MATCH <= dlc_hit;
				DATA_MATCH <= &byte_hit;
			end
		end
	end

endmodule
`default_nettype wire

/* File: testbench/test_wake_frame_filter_regs.sv */
// Self-checking bench for the wake frame filter register bank.
`timescale 1ns/1ps
`default_nettype none
module test_wake_frame_filter_regs;
	// Event bits: soft reset, restart, set, wake, changed, other write.
	logic [5:0] ev;
	logic clk, arst_n, stop_mode, rx_valid, wr, rd, rd_valid, addr_ok, cfg_valid;
	logic match_valid, id_ok, dlc_ok, data_ok, ok, v;
	logic [6:0] addr;
	logic [7:0] wdata, rdata, got;
	logic [7:0] rx_b [0:4];
	logic [20:0] exp_id, rx_id;
	logic [20:0] id_mask = 21'h1FE001;
	logic [3:0] rx_dlc, plen, len;
	int n_errors, comparisons, i, j;
	// Writable bits of 0x28 to 0x30, then one unmapped place.
	logic [7:0] wmask [0:9] = '{8'hFF, 8'hFF, 8'h7C, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
	// Clearing cases: event, stop state and flag left behind.
	logic [5:0] ev_tab [0:5] = '{6'h10, 6'h08, 6'h20, 6'h20, 6'h0C, 6'h01};
	logic [5:0] st_tab = 6'b000100;
	logic [5:0] ex_tab = 6'b001000;
	wffr_top u_dut (
		.CLK(clk), .ARST_N(arst_n), .SOFT_RST(ev[0]), .RESTART(ev[1]),
		.ADDR(addr), .WR(wr), .WDATA(wdata), .RD(rd), .RDATA(rdata),
		.RD_VALID(rd_valid), .ADDR_OK(addr_ok), .CFG_SET(ev[2]), .WAKE(ev[3]),
		.STOP_MODE(stop_mode), .EXT_CFG_WR(ev[5]), .EXT_CFG_CHANGED(ev[4]),
		.FILTER_CONFIG_VALID(cfg_valid), .EXP_ID(exp_id), .RX_VALID(rx_valid),
		.RX_ID(rx_id), .RX_DLC(rx_dlc), .RX_BYTE_SEVEN(rx_b[0]), .RX_BYTE_SIX(rx_b[1]),
		.RX_BYTE_FIVE(rx_b[2]), .RX_BYTE_FOUR(rx_b[3]), .RX_BYTE_THREE(rx_b[4]),
		.MATCH_VALID(match_valid), .ID_LOW_MATCH(id_ok), .DLC_MATCH(dlc_ok),
		.DATA_MATCH(data_ok), .PAYLOAD_LEN(plen)
	);
	wffr_host u_host (
		.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata),
		.rd_valid(rd_valid), .addr_ok(addr_ok)
	);
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask
	// One read with its strobe, hit flag and data checked.
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		u_host.read(a, got, ok, v);
		chk_bit("read strobe", 1'b1, v);
		chk_bit("address hit", a >= 7'h28 && a <= 7'h30, ok);
		chk_reg("read data", e, got);
	endtask
	// One-cycle event pulse; returns after the taking edge.
	task automatic pulse(input logic [5:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 6'h00;
	endtask
	// One received frame; results are looked at while the strobe stands.
	task automatic send;
		@(negedge clk);
		rx_valid = 1'b1;
		@(negedge clk);
		chk_bit("match strobe", 1'b1, match_valid);
		rx_valid = 1'b0;
	endtask
	task automatic complete_run;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// The sequence needs about three hundred cycles, so this only trips on a hang.
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		complete_run;
	end
	initial begin
		arst_n = 1'b0;
		ev = 6'h00;
		stop_mode = 1'b0;
		rx_valid = 1'b0;
		exp_id = 21'h15A5A5;
		rx_id = 21'h15A5A5;
		rx_dlc = 4'h0;
		for (i = 0; i < 5; i++) rx_b[i] = 8'h00;
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		for (i = 0; i < 11; i++) rd_chk(7'(7'h27 + i), 8'h00);
		for (i = 0; i < 10; i++) u_host.write(7'(7'h28 + i), 8'hFF);
		for (i = 0; i < 10; i++) rd_chk(7'(7'h28 + i), wmask[i]);
		for (i = 0; i < 9; i++) u_host.write(7'(7'h28 + i), 8'(8'h3C + 8'h13 * i));
		pulse(6'h02);
		for (i = 0; i < 9; i++) rd_chk(7'(7'h28 + i), 8'(8'h3C + 8'h13 * i) & wmask[i]);
		pulse(6'h01);
		for (i = 0; i < 9; i++) rd_chk(7'(7'h28 + i), 8'h00);
		pulse(6'h04);
		u_host.write(7'h28, 8'h00);
		chk_bit("config valid", 1'b1, cfg_valid);
		u_host.write(7'h28, 8'h01);
		chk_bit("config valid", 1'b0, cfg_valid);
		pulse(6'h04);
		stop_mode = 1'b1;
		u_host.write(7'h28, 8'h01);
		chk_bit("config valid", 1'b0, cfg_valid);
		stop_mode = 1'b0;
		for (i = 0; i < 6; i++) begin
			pulse(6'h04);
			stop_mode = st_tab[i];
			pulse(ev_tab[i]);
			chk_bit("config valid", ex_tab[i], cfg_valid);
			stop_mode = 1'b0;
		end
		u_host.write(7'h28, 8'hFF);
		u_host.write(7'h2A, 8'h04);
		for (i = 0; i < 5; i++) u_host.write(7'(7'h2C + i), 8'(8'h71 * (i + 1)));
		for (i = 0; i < 5; i++) rx_b[i] = 8'(8'h71 * (i + 1));
		for (i = 0; i < 21; i++) begin
			rx_id = exp_id ^ (21'h000001 << i);
			send;
			chk_bit("identifier match", ~id_mask[i], id_ok);
		end
		rx_id = exp_id;
		// One wrong byte walks across the payload; it only counts inside the length.
		for (i = 0; i < 16; i++) begin
			u_host.write(7'h2B, 8'(i));
			len = (i > 7) ? 4'h8 : 4'(i);
			j = 3 + i % 5;
			rx_b[7 - j] = ~rx_b[7 - j];
			rx_dlc = 4'(i);
			send;
			chk_reg("payload length", {4'h0, len}, {4'h0, plen});
			chk_bit("length code match", 1'b1, dlc_ok);
			chk_bit("data match", j >= len, data_ok);
			rx_dlc = 4'(i) ^ 4'h1;
			send;
			chk_bit("length code match", 1'b0, dlc_ok);
			rx_b[7 - j] = ~rx_b[7 - j];
		end
		complete_run;
	end
endmodule
`default_nettype wire

/* File: testbench/wffr_host.sv */
// Host model issuing byte writes and reads to the register bank.
`timescale 1ns/1ps
`default_nettype none
module wffr_host (
	// Clock.
	input wire logic clk,
	// Request lines.
	output logic [6:0] addr,
	output logic wr,
	output logic [7:0] wdata,
	output logic rd,
	// Answer lines.
	input wire logic [7:0] rdata,
	input wire logic rd_valid,
	input wire logic addr_ok
);
	// Strobes idle low before the first request.
	initial begin
		addr = 7'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Released lines show inverted values so a stale byte is never trusted.
	task automatic write(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	// The answer stands for the one cycle after the taking edge, so it is sampled
	// at the next falling edge, before the strobe is released.
	task automatic read(input logic [6:0] a, output logic [7:0] d, output logic ok, output logic v);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		v = rd_valid;
		d = rdata;
		ok = addr_ok;
		rd = 1'b0;
		addr = ~a;
	endtask
endmodule
`default_nettype wire

/* File: testbench/wffr_properties.sv */
// Port assertions for the wake frame filter register bank.
`timescale 1ns/1ps
`default_nettype none
module wffr_properties #(
	parameter ADDR_W = 7
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic ARST_N,
	// Register access.
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic RD_VALID,
	input wire logic ADDR_OK,
	// Valid flag events.
	input wire logic SOFT_RST,
	input wire logic CFG_SET,
	input wire logic WAKE,
	input wire logic STOP_MODE,
	input wire logic EXT_CFG_WR,
	input wire logic EXT_CFG_CHANGED,
	input wire logic FILTER_CONFIG_VALID,
	// Frame compare.
	input wire logic RX_VALID,
	input wire logic MATCH_VALID,
	input wire logic [3:0] PAYLOAD_LEN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// High when the address lies inside this bank.
	wire logic hit = ADDR >= 7'h28 && ADDR <= 7'h30;
	////////////////////////////////////////
	read_answer_a: assert property (RD |=> RD_VALID)
		else $error("read not answered");
	read_pulse_a: assert property (!RD |=> !RD_VALID)
		else $error("stray read strobe");
	unmapped_read_a: assert property (RD && !hit |=> RDATA == 8'h00 && !ADDR_OK)
		else $error("unmapped read not refused");
	mapped_read_a: assert property (RD && hit |=> ADDR_OK)
		else $error("mapped read refused");
	mask_reserved_a: assert property (RD && ADDR == 7'h2A |=> RDATA[7] == 1'b0 && RDATA[1:0] == 2'h0)
		else $error("mask reserved bits set");
	code_reserved_a: assert property (RD && ADDR == 7'h2B |=> RDATA[7:4] == 4'h0)
		else $error("length reserved bits set");
	length_cap_a: assert property (PAYLOAD_LEN <= 4'h8)
		else $error("payload length above eight");
	match_strobe_a: assert property (MATCH_VALID == $past(RX_VALID))
		else $error("match strobe misplaced");
	event_clear_a: assert property (WAKE || SOFT_RST || EXT_CFG_CHANGED |=> !FILTER_CONFIG_VALID)
		else $error("valid flag not cleared");
	stop_write_a: assert property (STOP_MODE && (WR && hit || EXT_CFG_WR) |=> !FILTER_CONFIG_VALID)
		else $error("stop write kept valid flag");
	valid_rise_a: assert property ($rose(FILTER_CONFIG_VALID) |-> $past(CFG_SET))
		else $error("valid flag rose unasked");
	valid_set_a: assert property (CFG_SET && !WAKE && !SOFT_RST && !WR && !EXT_CFG_WR && !EXT_CFG_CHANGED |=> FILTER_CONFIG_VALID)
		else $error("valid flag not set");
endmodule
bind wffr_top wffr_properties #(.ADDR_W(ADDR_W)) u_props (
	.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
	.RD_VALID(RD_VALID), .ADDR_OK(ADDR_OK), .SOFT_RST(SOFT_RST), .CFG_SET(CFG_SET),
	.WAKE(WAKE), .STOP_MODE(STOP_MODE), .EXT_CFG_WR(EXT_CFG_WR),
	.EXT_CFG_CHANGED(EXT_CFG_CHANGED), .FILTER_CONFIG_VALID(FILTER_CONFIG_VALID),
	.RX_VALID(RX_VALID), .MATCH_VALID(MATCH_VALID), .PAYLOAD_LEN(PAYLOAD_LEN)
);
`default_nettype wire
